/* uart_control_status_tb.sv */
// Self-checking bench for the serial port control and status block
module uart_control_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, serialIn, serialOut, shiftClkOut, irq;
	logic [8:0] got;
	logic [7:0] seed = 8'h23;
	logic [7:0] cv [5] = '{8'h40, 8'h40, 8'hc8, 8'hc0, 8'h88};
	int miscompares = 0, checks = 0, bitLen = 16, t, nb, rises = 0;
	always #50 ref_clk = ~ref_clk;
	// Shift clock rises once per bit, so a mode-0 byte must give eight rises
	always @(posedge shiftClkOut) rises++;
	ucs_top #(.CW(16)) i_ucs_top (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serialIn(serialIn), .serialOut(serialOut),
		.shiftClkOut(shiftClkOut), .irq(irq));
	ucs_remote i_ucs_remote (.ref_clk(ref_clk), .lineIn(serialOut), .lineOut(serialIn));
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Flag timing is judged to a few cycles: mid bit and bit edge differ by half a bit
	function logic [31:0] near(input int v, input int e);
		return {31'h0, (v >= e - 5) && (v <= e + 5)};
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [31:0] v);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps the next call from driving psel twice in this time step
		@(posedge ref_clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		apb(a, 1'b1, v);
	endtask
	task rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(nm, rd, e);
	endtask
	task clr(input logic [7:0] c);
		wr(12'h260, {24'h0, c});
		wr(12'h280, 32'h7);
	endtask
	task waitIrq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task rxFrame(input logic [8:0] b, input int k, input logic stp);
		fork
			i_ucs_remote.send(b, k, stp, bitLen);
			waitIrq(t);
		join
	endtask
	task conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rdChk("control", 12'h260, 32'h0);
		rdChk("extStatus", 12'h2e8, 32'h0);
		rdChk("baud", 12'h28c, 32'h57);
		apb(12'h000, 1'b0, 32'h0);
		chk("unmapped", {rd[30:0], perr}, 32'h1);
		wr(12'h28c, 32'h10);
		wr(12'h284, 32'h7);
		seed = lfsr(seed);
		clr(8'h50);
		rxFrame({1'b0, seed}, 8, 1'b1);
		chk("rxTime1", near(t, 155), 32'h1);
		rdChk("rxData1", 12'h264, {24'h0, seed});
		rdChk("rxStop1", 12'h260, 32'h55);
		clr(8'h40);
		rxFrame(9'h0a5, 8, 1'b1);
		rdChk("rxOff", 12'h280, 32'h0);
		clr(8'hf0);
		rxFrame(9'h0a5, 9, 1'b1);
		rdChk("rxFilt", 12'h280, 32'h0);
		seed = lfsr(seed);
		clr(8'hd0);
		rxFrame({seed[0], seed}, 9, 1'b1);
		chk("rxTime3", near(t, 155), 32'h1);
		rdChk("rxNinth3", 12'h260, {24'h0, 8'hd1 | {5'h0, seed[0], 2'h0}});
		wr(12'h288, 32'h1);
		clr(8'h50);
		rxFrame({1'b1, seed}, 9, 1'b1);
		chk("rxTime3e", near(t, 171), 32'h1);
		clr(8'h50);
		rxFrame(9'h155, 9, 1'b0);
		apb(12'h260, 1'b0, 32'h0);
		chk("feCtl", {31'h0, rd[7]}, 32'h1);
		apb(12'h2e8, 1'b0, 32'h0);
		chk("feStat", {31'h0, rd[3]}, 32'h1);
		clr(8'h50);
		apb(12'h260, 1'b0, 32'h0);
		chk("feClr", {31'h0, rd[7]}, 32'h0);
		wr(12'h288, 32'h0);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			bitLen = (i == 4) ? 32 : 16;
			nb = (i < 2) ? 8 : 9;
			clr(cv[i]);
			wr(12'h2e8, {25'h0, i[0], 6'h0});
			fork
				begin
					wr(12'h264, {24'h0, seed});
					waitIrq(t);
				end
				i_ucs_remote.recv(nb, bitLen, got);
			join
			chk("txTime", near(t, (nb + 1 + i[0]) * bitLen + 1), 32'h1);
			chk("txData", {23'h0, got}, {23'h0, cv[i][3] & (nb == 9), seed});
			repeat (bitLen) @(posedge ref_clk);
		end
		clr(8'h00);
		wr(12'h2e8, 32'h0);
		nb = rises;
		wr(12'h264, 32'h3c);
		waitIrq(t);
		chk("txTime0", near(t, 129), 32'h1);
		chk("shiftClk", rises - nb, 32'h8);
		repeat (20) @(posedge ref_clk);
		wr(12'h284, 32'h0);
		clr(8'h10);
		repeat (100) @(posedge ref_clk);
		rdChk("rx0Early", 12'h280, 32'h0);
		repeat (40) @(posedge ref_clk);
		rdChk("rx0Flag", 12'h280, 32'h2);
		chk("irqMasked", {31'h0, irq}, 32'h0);
		wr(12'h284, 32'h2);
		chk("irqOn", {31'h0, irq}, 32'h1);
		wr(12'h280, 32'h2);
		chk("irqClr", {31'h0, irq}, 32'h0);
		conclude;
	end
endmodule

/* ucs_params.svh */
// Register indices, field positions, reset values and bit timing for the serial port block
`ifndef UCS_PARAMS_SVH
`define UCS_PARAMS_SVH

`define UCS_IDX_SERIAL_PORT_CONTROL 10'h098
`define UCS_IDX_SERIAL_DATA 10'h099
`define UCS_IDX_SERIAL_EXTENDED_STATUS 10'h0ba
`define UCS_IDX_IRQ_STATUS 10'h0a0
`define UCS_IDX_IRQ_MASK 10'h0a1
`define UCS_IDX_MODE_CONFIG 10'h0a2
`define UCS_IDX_BAUD_PERIOD 10'h0a3

`define UCS_SPC_RESET 8'h00
`define UCS_SES_RESET 8'h00
`define UCS_BAUD_RESET 16'h0057

`define UCS_SPC_MODE_HIGH 7
`define UCS_SPC_MODE_LOW 6
`define UCS_SPC_MULTIPROC 5
`define UCS_SPC_RX_EN 4
`define UCS_SPC_TX_NINTH 3
`define UCS_SPC_RX_NINTH 2
`define UCS_SPC_TX_FLAG 1
`define UCS_SPC_RX_FLAG 0

`define UCS_SES_DB_ENABLE 7
`define UCS_SES_TX_LATE 6
`define UCS_SES_SPLIT_IRQ 5
`define UCS_SES_DB_IRQ_SEL 4
`define UCS_SES_FRAMING 3
`define UCS_SES_LONG_LOW 2
`define UCS_SES_OVERRUN 1
`define UCS_SES_STATUS_IRQ 0

`define UCS_CFG_ERR_SEL 0

`define UCS_IRQ_TX 0
`define UCS_IRQ_RX 1
`define UCS_IRQ_FE 2

`define UCS_MODE_SHIFT 2'h0
`define UCS_MODE_UART8 2'h1
`define UCS_MODE_UART9F 2'h2
`define UCS_MODE_UART9V 2'h3

`define UCS_MODE0_DIV 16
`define UCS_MODE2_DIV 32

`endif

/* ucs_pkg.sv */
// Types shared by the serial port control and status block
package ucs_pkg;
	typedef logic [1:0] ucs_mode_t;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} ucs_state_t;
endpackage

/* ucs_remote.sv */
// Remote serial device model facing the block's serial pins
module ucs_remote (
	input wire logic ref_clk,
	input wire logic lineIn,
	output logic lineOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// The line idles high, as a real transmitter leaves it between frames
	initial lineOut = 1'b1;
	task automatic send(input logic [8:0] b, input int nb, input logic stp, input int len);
		lineOut <= 1'b0;
		repeat (len) @(posedge ref_clk);
		for (int k = 0; k < nb; k++) begin
			lineOut <= b[k];
			repeat (len) @(posedge ref_clk);
		end
		lineOut <= stp;
		repeat (len) @(posedge ref_clk);
		lineOut <= 1'b1;
	endtask
	// Samples mid bit; the bound keeps a silent transmitter from hanging us
	task automatic recv(input int nb, input int len, output logic [8:0] b);
		int n;
		b = 9'h0;
		n = 0;
		while (lineIn !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (len / 2) @(posedge ref_clk);
		for (int k = 0; k < nb; k++) begin
			repeat (len) @(posedge ref_clk);
			b[k] = lineIn;
		end
	endtask
endmodule

/* ucs_rx.sv */
// Serial receiver: shift-register mode and 8/9-bit frames with flag timing
`include "ucs_params.svh"
module ucs_rx #(
	parameter int CW = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic rxd,
	input wire logic enable,
	input wire logic riFlag,
	input wire ucs_pkg::ucs_mode_t mode,
	input wire logic [CW-1:0] bitLen,
	input wire logic errSel,
	input wire logic multiproc,
	output logic [7:0] data,
	output logic ninth,
	output logic riPulse,
	output logic feEvent,
	output logic shiftClk,
	output logic active
);
	import ucs_pkg::*;
	ucs_state_t state;
	ucs_mode_t fMode;
	logic [CW-1:0] cnt;
	logic [3:0] bitIdx;
	logic [7:0] shreg;
	logic ninthSample;
	logic tick;
	logic fShift;
	logic riNinth;
	logic riStop;

	assign fShift = (fMode == `UCS_MODE_SHIFT);
	assign tick = (state != ST_IDLE) && (cnt == '0);
	assign active = (state != ST_IDLE);
	assign riNinth = tick && state == ST_NINTH && !errSel && (!multiproc || rxd); // R6
	assign riStop = tick && state == ST_STOP &&
		((fMode == `UCS_MODE_UART8 && (!multiproc || rxd)) ||
		(fMode[1] && errSel && (!multiproc || ninthSample))); // R5 R7
	assign riPulse = (tick && fShift && state == ST_DATA && bitIdx == 4'h7) || riNinth || riStop; // R4
	assign feEvent = tick && state == ST_STOP && !rxd; // R10

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			fMode <= `UCS_MODE_SHIFT;
			cnt <= '0;
			bitIdx <= 4'h0;
			shreg <= 8'h00;
			ninthSample <= 1'b0;
		end else if (state == ST_IDLE) begin
			bitIdx <= 4'h0;
			fMode <= mode;
			// New frames only start while reception is enabled
			if (enable && mode == `UCS_MODE_SHIFT && !riFlag) begin // R1
				state <= ST_DATA;
				cnt <= bitLen - CW'(1);
			end else if (enable && mode != `UCS_MODE_SHIFT && !rxd) begin // R1
				state <= ST_START;
				cnt <= (bitLen >> 1) - CW'(1);
			end
		end else if (fShift && cnt == (bitLen >> 1)) begin
			shreg <= {rxd, shreg[7:1]};
			cnt <= cnt - CW'(1);
		end else if (cnt != '0) begin
			cnt <= cnt - CW'(1);
		end else begin
			cnt <= bitLen - CW'(1);
			unique case (state)
				ST_IDLE: begin
				end
				// A start bit that is high again at mid-bit was noise
				ST_START: state <= rxd ? ST_IDLE : ST_DATA;
				ST_DATA: begin
					if (!fShift) begin
						shreg <= {rxd, shreg[7:1]};
					end
					if (bitIdx == 4'h7) begin
						state <= fShift ? ST_IDLE : (fMode[1] ? ST_NINTH : ST_STOP);
					end else begin
						bitIdx <= bitIdx + 4'h1;
					end
				end
				ST_NINTH: begin
					ninthSample <= rxd;
					state <= ST_STOP;
				end
				// Return at mid stop bit to resynchronise on the next start edge
				ST_STOP: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			data <= 8'h00;
			ninth <= 1'b0;
		end else if (riPulse) begin
			// Shift mode has already taken all eight mid-bit samples by the last tick
			data <= shreg;
			if (riNinth) begin
				ninth <= rxd; // R2
			end else if (riStop) begin
				ninth <= (fMode == `UCS_MODE_UART8) ? rxd : ninthSample; // R2
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			shiftClk <= 1'b1;
		end else begin
			shiftClk <= !(state == ST_DATA && fShift && cnt > (bitLen >> 1));
		end
	end

	property p_rxShiftFlag;
		@(posedge ref_clk) disable iff (!resetn)
			(riPulse && fShift) |-> (state == ST_DATA && bitIdx == 4'h7 && cnt == '0);
	endproperty
	a_rxShiftFlag: assert property (p_rxShiftFlag) else $error("shift rx flag mistimed"); // R4

	property p_rxEightStop;
		@(posedge ref_clk) disable iff (!resetn)
			(riPulse && fMode == `UCS_MODE_UART8) |-> (state == ST_STOP) ##1 (ninth == $past(rxd));
	endproperty
	a_rxEightStop: assert property (p_rxEightStop) else $error("8-bit rx flag or stop copy wrong"); // R5

	property p_rxNinthFlag;
		@(posedge ref_clk) disable iff (!resetn)
			(riPulse && fMode[1] && !errSel) |-> (state == ST_NINTH) ##1 (ninth == $past(rxd));
	endproperty
	a_rxNinthFlag: assert property (p_rxNinthFlag) else $error("9-bit rx flag not at bit 8"); // R6

	property p_rxStopFlag;
		@(posedge ref_clk) disable iff (!resetn)
			(riPulse && fMode[1] && errSel) |-> (state == ST_STOP);
	endproperty
	a_rxStopFlag: assert property (p_rxStopFlag) else $error("9-bit rx flag not at stop"); // R7

	property p_rxNinthHeld;
		@(posedge ref_clk) disable iff (!resetn)
			(riStop && fMode[1]) |=> (ninth == $past(ninthSample));
	endproperty
	a_rxNinthHeld: assert property (p_rxNinthHeld) else $error("received ninth bit lost"); // R2
endmodule

/* ucs_top.sv */
// Serial port control and status block with APB register access and interrupt
`include "ucs_params.svh"
// Function
// [R1] Reception starts only while the receive enable bit is set and stops taking new frames once cleared.
// [R2] The receive ninth-bit field holds bit 8 in nine-bit modes, the stop bit in 8-bit mode, and is undefined in shift mode.
// [R3] The transmit flag is set at the end of the 8th bit in shift mode and at the stop bit otherwise, and only software clears it.
// [R4] In shift mode the receive flag is set at the end of the 8th bit and stays until software clears it.
// [R5] In 8-bit mode the receive flag is set about halfway through the stop bit.
// [R6] In nine-bit modes with error-bit select clear, the receive flag is set near the middle of bit 8.
// [R7] In nine-bit modes with error-bit select set, the receive flag is set near the middle of the stop bit, subject to multiprocessor filtering.
// [R8] The two mode bits select shift, 8-bit variable, or nine-bit modes, with shift mode after reset.
// [R9] The transmit flag comes at the start of the stop bit when the late select is clear and at its end when set.
// [R10] With error-bit select set, the control top bit is a framing error flag set on a bad stop bit and cleared by software.
// [R11] In nine-bit modes the transmitter sends the software-written ninth bit as data bit nine.
module ucs_top #(
	parameter int CW = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serialIn,
	output logic serialOut,
	output logic shiftClkOut,
	output logic irq
);
	import ucs_pkg::*;
	localparam logic [7:0] SPC_RST = `UCS_SPC_RESET;
	localparam logic [7:0] SES_RST = `UCS_SES_RESET;

	logic modeSelectHigh;
	logic modeSelectLow;
	logic multiprocEnable;
	logic rxEnable;
	logic txNinthBit;
	logic rxNinthBit;
	logic transmitInterruptFlag;
	logic receiveDoneFlag;
	logic framingErrorFlag;
	logic overrunFlag;
	logic txDoubleBufferEnable;
	logic txIrqLateSelect;
	logic splitRxTxIrq;
	logic doubleBufferIrqSelect;
	logic statusIrqEnable;
	logic errorBitSelect;
	logic [CW-1:0] baudPeriod;
	logic [2:0] irqStatus;
	logic [2:0] irqMask;
	logic [7:0] rxData;
	ucs_mode_t mode;
	logic [CW-1:0] bitLen;
	logic txBusy;
	logic txEvent;
	logic rxEvent;
	logic feEvent;
	logic rxActive;
	logic txShiftClk;
	logic rxShiftClk;
	logic [9:0] idx;
	logic mapped;
	logic wrAccess;
	logic wrSpc;
	logic wrSes;
	logic wrData;
	logic [7:0] spcRead;
	logic [7:0] sesRead;
	logic [31:0] readMux;
	logic [2:0] events;

	assign mode = {modeSelectHigh, modeSelectLow};

	always_comb begin
		unique case (mode)
			`UCS_MODE_SHIFT: bitLen = CW'(`UCS_MODE0_DIV); // R8
			`UCS_MODE_UART9F: bitLen = CW'(`UCS_MODE2_DIV); // R8
			default: bitLen = baudPeriod; // R8
		endcase
	end

	// APB decode: every register answers without wait states
	assign idx = paddr[11:2];
	assign mapped = (idx == `UCS_IDX_SERIAL_PORT_CONTROL) || (idx == `UCS_IDX_SERIAL_DATA) ||
		(idx == `UCS_IDX_SERIAL_EXTENDED_STATUS) || (idx == `UCS_IDX_IRQ_STATUS) ||
		(idx == `UCS_IDX_IRQ_MASK) || (idx == `UCS_IDX_MODE_CONFIG) ||
		(idx == `UCS_IDX_BAUD_PERIOD);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wrAccess = psel && penable && pwrite && mapped;
	assign wrSpc = wrAccess && idx == `UCS_IDX_SERIAL_PORT_CONTROL;
	assign wrSes = wrAccess && idx == `UCS_IDX_SERIAL_EXTENDED_STATUS;
	assign wrData = wrAccess && idx == `UCS_IDX_SERIAL_DATA;

	// The top control bit doubles as the framing flag when error-bit select is set
	assign spcRead = {errorBitSelect ? framingErrorFlag : modeSelectHigh, modeSelectLow, // R10
		multiprocEnable, rxEnable, txNinthBit, rxNinthBit, transmitInterruptFlag,
		receiveDoneFlag};
	assign sesRead = {txDoubleBufferEnable, txIrqLateSelect, splitRxTxIrq,
		doubleBufferIrqSelect, framingErrorFlag, 1'b0, overrunFlag, statusIrqEnable};

	always_comb begin
		readMux = 32'h00000000;
		unique case (idx)
			`UCS_IDX_SERIAL_PORT_CONTROL: readMux[7:0] = spcRead;
			`UCS_IDX_SERIAL_DATA: readMux[7:0] = rxData;
			`UCS_IDX_SERIAL_EXTENDED_STATUS: readMux[7:0] = sesRead;
			`UCS_IDX_IRQ_STATUS: readMux[2:0] = irqStatus;
			`UCS_IDX_IRQ_MASK: readMux[2:0] = irqMask;
			`UCS_IDX_MODE_CONFIG: readMux[`UCS_CFG_ERR_SEL] = errorBitSelect;
			`UCS_IDX_BAUD_PERIOD: readMux[CW-1:0] = baudPeriod;
			default: readMux = 32'h00000000;
		endcase
	end

	// Read data is captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= (pwrite || !mapped) ? 32'h00000000 : readMux;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			modeSelectHigh <= SPC_RST[`UCS_SPC_MODE_HIGH]; // R8
			modeSelectLow <= SPC_RST[`UCS_SPC_MODE_LOW]; // R8
			multiprocEnable <= SPC_RST[`UCS_SPC_MULTIPROC];
			rxEnable <= SPC_RST[`UCS_SPC_RX_EN];
			txNinthBit <= SPC_RST[`UCS_SPC_TX_NINTH];
		end else if (wrSpc) begin
			if (!errorBitSelect) begin
				modeSelectHigh <= pwdata[`UCS_SPC_MODE_HIGH]; // R8
			end
			modeSelectLow <= pwdata[`UCS_SPC_MODE_LOW];
			multiprocEnable <= pwdata[`UCS_SPC_MULTIPROC];
			rxEnable <= pwdata[`UCS_SPC_RX_EN]; // R1
			txNinthBit <= pwdata[`UCS_SPC_TX_NINTH]; // R11
		end
	end

	// Hardware set beats a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			transmitInterruptFlag <= SPC_RST[`UCS_SPC_TX_FLAG];
			receiveDoneFlag <= SPC_RST[`UCS_SPC_RX_FLAG];
		end else begin
			if (txEvent) begin
				transmitInterruptFlag <= 1'b1; // R3
			end else if (wrSpc) begin
				transmitInterruptFlag <= pwdata[`UCS_SPC_TX_FLAG]; // R3
			end
			if (rxEvent) begin
				receiveDoneFlag <= 1'b1; // R4
			end else if (wrSpc) begin
				receiveDoneFlag <= pwdata[`UCS_SPC_RX_FLAG]; // R4
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			framingErrorFlag <= SES_RST[`UCS_SES_FRAMING];
			overrunFlag <= SES_RST[`UCS_SES_OVERRUN];
		end else begin
			if (feEvent) begin
				framingErrorFlag <= 1'b1; // R10
			end else if (wrSpc && errorBitSelect) begin
				framingErrorFlag <= pwdata[`UCS_SPC_MODE_HIGH]; // R10
			end else if (wrSes) begin
				framingErrorFlag <= pwdata[`UCS_SES_FRAMING];
			end
			if (rxEvent && receiveDoneFlag) begin
				overrunFlag <= 1'b1;
			end else if (wrSes) begin
				overrunFlag <= pwdata[`UCS_SES_OVERRUN];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			txDoubleBufferEnable <= SES_RST[`UCS_SES_DB_ENABLE];
			txIrqLateSelect <= SES_RST[`UCS_SES_TX_LATE];
			splitRxTxIrq <= SES_RST[`UCS_SES_SPLIT_IRQ];
			doubleBufferIrqSelect <= SES_RST[`UCS_SES_DB_IRQ_SEL];
			statusIrqEnable <= SES_RST[`UCS_SES_STATUS_IRQ];
		end else if (wrSes) begin
			txDoubleBufferEnable <= pwdata[`UCS_SES_DB_ENABLE];
			txIrqLateSelect <= pwdata[`UCS_SES_TX_LATE]; // R9
			splitRxTxIrq <= pwdata[`UCS_SES_SPLIT_IRQ];
			doubleBufferIrqSelect <= pwdata[`UCS_SES_DB_IRQ_SEL];
			statusIrqEnable <= pwdata[`UCS_SES_STATUS_IRQ];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			errorBitSelect <= 1'b0;
			baudPeriod <= CW'(`UCS_BAUD_RESET);
			irqMask <= 3'h0;
		end else begin
			if (wrAccess && idx == `UCS_IDX_MODE_CONFIG) begin
				errorBitSelect <= pwdata[`UCS_CFG_ERR_SEL];
			end
			// A period below two cycles would leave no mid-bit sample point
			if (wrAccess && idx == `UCS_IDX_BAUD_PERIOD && pwdata[CW-1:1] != '0) begin
				baudPeriod <= pwdata[CW-1:0];
			end
			if (wrAccess && idx == `UCS_IDX_IRQ_MASK) begin
				irqMask <= pwdata[2:0];
			end
		end
	end

	assign events = {feEvent, rxEvent, txEvent};

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			irqStatus <= 3'h0;
		end else if (wrAccess && idx == `UCS_IDX_IRQ_STATUS) begin
			irqStatus <= (irqStatus & ~pwdata[2:0]) | events;
		end else begin
			irqStatus <= irqStatus | events;
		end
	end

	assign irq = |(irqStatus & irqMask);
	assign shiftClkOut = txShiftClk & rxShiftClk;

	// A write while a frame is on the line is dropped rather than corrupting it
	ucs_tx #(
		.CW(CW)
	) u_tx (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(wrData && !txBusy),
		.data(pwdata[7:0]),
		.ninth(txNinthBit),
		.mode(mode),
		.bitLen(bitLen),
		.lateIrq(txIrqLateSelect),
		.txd(serialOut),
		.shiftClk(txShiftClk),
		.busy(txBusy),
		.tiPulse(txEvent)
	);

	ucs_rx #(
		.CW(CW)
	) u_rx (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.rxd(serialIn),
		.enable(rxEnable),
		.riFlag(receiveDoneFlag),
		.mode(mode),
		.bitLen(bitLen),
		.errSel(errorBitSelect),
		.multiproc(multiprocEnable),
		.data(rxData),
		.ninth(rxNinthBit),
		.riPulse(rxEvent),
		.feEvent(feEvent),
		.shiftClk(rxShiftClk),
		.active(rxActive)
	);

	property p_rxGate;
		@(posedge ref_clk) disable iff (!resetn) $rose(rxActive) |-> $past(rxEnable);
	endproperty
	a_rxGate: assert property (p_rxGate) else $error("reception began while disabled"); // R1

	property p_txFlag;
		@(posedge ref_clk) disable iff (!resetn) txEvent |=> transmitInterruptFlag;
	endproperty
	a_txFlag: assert property (p_txFlag) else $error("tx flag not set by event"); // R3

	property p_rxFlagHold;
		@(posedge ref_clk) disable iff (!resetn)
			(receiveDoneFlag && !wrSpc) |=> receiveDoneFlag;
	endproperty
	a_rxFlagHold: assert property (p_rxFlagHold) else $error("rx flag dropped without write"); // R4

	property p_rxFlag;
		@(posedge ref_clk) disable iff (!resetn) rxEvent |=> receiveDoneFlag;
	endproperty
	a_rxFlag: assert property (p_rxFlag) else $error("rx flag not set by event"); // R4

	property p_feFlag;
		@(posedge ref_clk) disable iff (!resetn)
			(feEvent && errorBitSelect) |=> (framingErrorFlag && spcRead[7]);
	endproperty
	a_feFlag: assert property (p_feFlag) else $error("framing flag not visible"); // R10

	property p_modeLen;
		@(posedge ref_clk) disable iff (!resetn)
			(mode == `UCS_MODE_SHIFT) |-> (bitLen == CW'(`UCS_MODE0_DIV));
	endproperty
	a_modeLen: assert property (p_modeLen) else $error("shift mode bit length wrong"); // R8

	property p_irqOut;
		@(posedge ref_clk) disable iff (!resetn)
			(txEvent && irqMask[`UCS_IRQ_TX]) |=> irq;
	endproperty
	a_irqOut: assert property (p_irqOut) else $error("unmasked event gave no interrupt");
endmodule

/* ucs_tx.sv */
// Serial transmitter: shift-register mode and 8/9-bit frames
`include "ucs_params.svh"
module ucs_tx #(
	parameter int CW = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [7:0] data,
	input wire logic ninth,
	input wire ucs_pkg::ucs_mode_t mode,
	input wire logic [CW-1:0] bitLen,
	input wire logic lateIrq,
	output logic txd,
	output logic shiftClk,
	output logic busy,
	output logic tiPulse
);
	import ucs_pkg::*;
	ucs_state_t state;
	ucs_mode_t fMode;
	logic [CW-1:0] cnt;
	logic [3:0] bitIdx;
	logic [7:0] shreg;
	logic ninthLatch;
	logic fShift;
	logic lastTick;
	logic lastData;

	assign fShift = (fMode == `UCS_MODE_SHIFT);
	assign lastTick = (state != ST_IDLE) && (cnt == '0);
	assign lastData = (state == ST_DATA) && (bitIdx == 4'h7);
	assign busy = (state != ST_IDLE);
	// Early position fires on the tick that enters the stop bit
	assign tiPulse = lastTick && ((fShift && lastData) ||
		(!fShift && lateIrq && state == ST_STOP) ||
		(!fShift && !lateIrq && (state == ST_NINTH || (lastData && !fMode[1])))); // R3 R9

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			fMode <= `UCS_MODE_SHIFT;
			cnt <= '0;
			bitIdx <= 4'h0;
			shreg <= 8'h00;
			ninthLatch <= 1'b0;
			txd <= 1'b1;
		end else if (state == ST_IDLE) begin
			if (start) begin
				shreg <= data;
				ninthLatch <= ninth; // R11
				fMode <= mode;
				bitIdx <= 4'h0;
				cnt <= bitLen - CW'(1);
				if (mode == `UCS_MODE_SHIFT) begin
					state <= ST_DATA;
					txd <= data[0];
				end else begin
					state <= ST_START;
					txd <= 1'b0;
				end
			end
		end else if (cnt != '0) begin
			cnt <= cnt - CW'(1);
		end else begin
			cnt <= bitLen - CW'(1);
			unique case (state)
				ST_IDLE: begin
				end
				ST_START: begin
					state <= ST_DATA;
					txd <= shreg[0];
				end
				ST_DATA: begin
					if (bitIdx == 4'h7) begin
						if (fShift) begin
							state <= ST_IDLE;
							txd <= 1'b1;
						end else if (fMode[1]) begin
							state <= ST_NINTH;
							txd <= ninthLatch; // R11
						end else begin
							state <= ST_STOP;
							txd <= 1'b1;
						end
					end else begin
						bitIdx <= bitIdx + 4'h1;
						shreg <= {1'b0, shreg[7:1]};
						txd <= shreg[1];
					end
				end
				ST_NINTH: begin
					state <= ST_STOP;
					txd <= 1'b1;
				end
				ST_STOP: begin
					state <= ST_IDLE;
					txd <= 1'b1;
				end
			endcase
		end
	end

	// Shift clock idles high, rises mid-bit so the partner samples stable data
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			shiftClk <= 1'b1;
		end else begin
			shiftClk <= !(state == ST_DATA && fShift && cnt > (bitLen >> 1));
		end
	end

	property p_txShiftEnd;
		@(posedge ref_clk) disable iff (!resetn) (tiPulse && fShift) |=> (state == ST_IDLE);
	endproperty
	a_txShiftEnd: assert property (p_txShiftEnd) else $error("tx flag not at end of 8th bit"); // R3

	property p_txEarly;
		@(posedge ref_clk) disable iff (!resetn)
			(tiPulse && !fShift && !lateIrq) |=> (state == ST_STOP && txd);
	endproperty
	a_txEarly: assert property (p_txEarly) else $error("early tx flag not at stop start"); // R9

	property p_txLate;
		@(posedge ref_clk) disable iff (!resetn)
			(tiPulse && !fShift && lateIrq) |-> (state == ST_STOP && cnt == '0);
	endproperty
	a_txLate: assert property (p_txLate) else $error("late tx flag not at stop end"); // R9

	property p_txNinth;
		@(posedge ref_clk) disable iff (!resetn)
			(state == ST_NINTH) |-> (txd == ninthLatch);
	endproperty
	a_txNinth: assert property (p_txNinth) else $error("ninth bit on line differs"); // R11
endmodule
